// ---- amc_pkg.sv ----
// constants and types for the operating state control block
package amc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_ADDR = 8'h10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] BURST_LEN_ADDR = 8'h29;

  // ==========================================================
  // control register fields
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  localparam int RESV_BIT = 3;
  localparam int X_OFF_BIT = 4;
  localparam int Y_OFF_BIT = 5;
  localparam int Z_OFF_BIT = 6;
  localparam int BURST_CMD_BIT = 7;

  // ==========================================================
  // state select codes
  localparam logic [2:0] SEL_SLEEP = 3'h0;
  localparam logic [2:0] SEL_STANDBY = 3'h1;
  localparam logic [2:0] SEL_WATCH = 3'h2;
  localparam logic [2:0] SEL_CONT = 3'h5;
  localparam logic [2:0] SEL_COMBINED = 3'h6;
  localparam logic [2:0] SEL_BURST = 3'h7;

  // ==========================================================
  // burst length
  localparam logic [7:0] BURST_ENDLESS = 8'hff;
  localparam logic [7:0] BURST_MIN = 8'h01;
  localparam logic [7:0] BURST_ONE = 8'h01;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int HB_MAX_EDGES = 3;
  localparam int REPORT_LAG_MIN_US = 2;
  localparam int REPORT_LAG_MAX_US = 10;
  localparam int NS_PER_US = 1000;
  // least lag rounds up to whole cycles
  localparam int REPORT_LAG_CYCLES =
    (REPORT_LAG_MIN_US * NS_PER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAG_W = 20;

  // ==========================================================
  // operating states, one-hot
  typedef enum logic [5:0] {
    ST_SLEEP    = 6'h01,
    ST_STANDBY  = 6'h02,
    ST_WATCH    = 6'h04,
    ST_CONT     = 6'h08,
    ST_COMBINED = 6'h10,
    ST_BURST    = 6'h20
  } amc_state_t;

endpackage

// ---- amc_heartbeat_sync.sv ----
// heartbeat synchroniser with agreement filter and transition pulse
`timescale 1ns/1ps
module amc_heartbeat_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // heartbeat level from outside the domain
  input wire logic hb_i,
  // one pulse per accepted heartbeat transition
  output logic hb_edge_o
);

  // ==========================================================
  // three stage synchroniser
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic stable_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= hb_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // ==========================================================
  // a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stable_ff <= 1'b0;
      hb_edge_o <= 1'b0;
    end else begin
      hb_edge_o <= 1'b0;
      if ((sync2_ff == sync3_ff) && (sync3_ff != stable_ff)) begin
        stable_ff <= sync3_ff;
        hb_edge_o <= 1'b1;
      end
    end
  end

endmodule

// ---- amc_mode_control.sv ----
// operating state control register and state machine
// What this block does
// [RL1] write-only eight-bit control register at 0x10, reset 0x00
// [RL2] commanded state change completes within three heartbeat transitions
// [RL3] hardware may rewrite the state select field on automatic events
// [RL4] reported state lags the written state by 2 to 10 ms
// [RL5] code 000 sleep: clocks stop, partial power down
// [RL6] code 001 standby: clocks run, no sampling
// [RL7] code 010 activity watch, moving to continuous sampling on activity
// [RL8] code 101 continuous three-axis sampling, watch circuitry off
// [RL9] code 110 watch, sampling and optional FIFO together
// [RL10] code 111 counted burst then back to sleep
// [RL11] bits 4, 5, 6 switch off X, Y, Z channels
// [RL12] writing bit 7 starts a one-shot counted burst
// [RL13] burst length 255 samples without end
// [RL14] burst length comes from the shadow register at 0x29
// [RL15] burst starts are accepted only from standby
// [RL16] outside trigger only with code 111, never with burst command; here an enabled outside trigger refuses every burst start, code 111 included
// [RL17] host avoids codes 011, 100 and writes zero to bit 3
`timescale 1ns/1ps
module amc_mode_control #(
  parameter int LAG_CYCLES = amc_pkg::REPORT_LAG_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // register write port from the host interface logic
  input wire logic WR_STB_I,
  input wire logic [7:0] WR_ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  // heartbeat clock, from outside this domain
  input wire logic HEARTBEAT_I,
  // events from the sensing logic
  input wire logic ACTIVITY_I,
  input wire logic SAMPLE_DONE_I,
  input wire logic [7:0] BURST_LENGTH_I,
  input wire logic OUTSIDE_TRIGGER_ENABLE_I,
  // state select field as hardware holds it
  output logic [2:0] STATE_SELECT_O,
  // reported current state for the status register
  output logic [2:0] REPORTED_STATE_O,
  // controls to the sensing logic
  output logic CLOCKS_EN_O,
  output logic POWER_DOWN_O,
  output logic WATCH_EN_O,
  output logic SAMPLING_EN_O,
  output logic FIFO_ALLOW_O,
  output logic BURST_ACTIVE_O,
  output logic [2:0] CHANNEL_EN_O
);

  // ==========================================================
  // declarations
  typedef amc_pkg::amc_state_t amc_state_t;

  logic hb_edge;
  logic ctrl_wr;
  logic [7:0] ctrl_ff;
  logic pending_ff;
  logic burst_req_ff;
  logic [1:0] hb_count_ff;
  amc_state_t state_ff;
  amc_state_t nxt_state;
  logic hw_set;
  logic [2:0] hw_sel;
  logic burst_go;
  logic [7:0] burst_len_ff;
  logic [7:0] burst_cnt_ff;
  logic burst_last;
  logic [2:0] state_code;
  logic [2:0] last_code_ff;
  logic [amc_pkg::LAG_W-1:0] lag_cnt_ff;
  logic apply;

  // ==========================================================
  // heartbeat transitions
  amc_heartbeat_sync u_hb_sync (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .hb_i(HEARTBEAT_I),
    .hb_edge_o(hb_edge)
  );

  // ==========================================================
  // control register write
  assign ctrl_wr = WR_STB_I && (WR_ADDR_I == amc_pkg::CTRL_ADDR); // see [RL1]

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_ff <= amc_pkg::CTRL_RESET; // see [RL1]
    end else if (ctrl_wr) begin
      ctrl_ff <= WR_DATA_I;
      ctrl_ff[amc_pkg::BURST_CMD_BIT] <= 1'b0;
    end else if (hw_set) begin
      ctrl_ff[amc_pkg::SEL_MSB:amc_pkg::SEL_LSB] <= hw_sel; // see [RL3]
    end
  end

  // ==========================================================
  // pending change, applied on a heartbeat transition
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pending_ff <= 1'b0;
      burst_req_ff <= 1'b0;
      hb_count_ff <= 2'h0;
    end else if (ctrl_wr) begin
      pending_ff <= 1'b1;
      burst_req_ff <= WR_DATA_I[amc_pkg::BURST_CMD_BIT]; // see [RL12]
      hb_count_ff <= 2'h0;
    end else if (apply) begin
      pending_ff <= 1'b0;
      burst_req_ff <= 1'b0;
      hb_count_ff <= 2'h0;
    end else if (pending_ff && hb_edge) begin
      hb_count_ff <= hb_count_ff + 2'h1;
    end
  end

  // first heartbeat transition after the write takes the change
  assign apply = pending_ff && hb_edge; // see [RL2]

  // ==========================================================
  // automatic events
  assign burst_last = SAMPLE_DONE_I && (burst_len_ff != amc_pkg::BURST_ENDLESS) &&
                      (burst_cnt_ff + amc_pkg::BURST_ONE >= burst_len_ff); // see [RL13]
  assign burst_go = apply && (state_ff == amc_pkg::ST_STANDBY) &&
                    !OUTSIDE_TRIGGER_ENABLE_I && // see [RL16]
                    (burst_req_ff ||
                     (ctrl_ff[amc_pkg::SEL_MSB:amc_pkg::SEL_LSB] == amc_pkg::SEL_BURST));

  always_comb begin
    hw_set = 1'b0;
    hw_sel = amc_pkg::SEL_SLEEP;
    if ((state_ff == amc_pkg::ST_WATCH) && ACTIVITY_I && !apply) begin
      hw_set = 1'b1;
      hw_sel = amc_pkg::SEL_CONT; // see [RL7]
    end else if ((state_ff == amc_pkg::ST_BURST) && burst_last && !apply) begin
      hw_set = 1'b1;
      hw_sel = amc_pkg::SEL_SLEEP; // see [RL10]
    end else if (burst_go && burst_req_ff) begin
      hw_set = 1'b1;
      hw_sel = amc_pkg::SEL_BURST; // see [RL3]
    end
  end

  // ==========================================================
  // operating state machine
  always_comb begin
    nxt_state = state_ff;
    if (apply) begin
      unique case (ctrl_ff[amc_pkg::SEL_MSB:amc_pkg::SEL_LSB])
        amc_pkg::SEL_SLEEP: nxt_state = amc_pkg::ST_SLEEP; // see [RL5]
        amc_pkg::SEL_STANDBY: nxt_state = amc_pkg::ST_STANDBY; // see [RL6]
        amc_pkg::SEL_WATCH: nxt_state = amc_pkg::ST_WATCH; // see [RL7]
        amc_pkg::SEL_CONT: nxt_state = amc_pkg::ST_CONT; // see [RL8]
        amc_pkg::SEL_COMBINED: nxt_state = amc_pkg::ST_COMBINED; // see [RL9]
        amc_pkg::SEL_BURST: begin
          if (burst_go) begin
            nxt_state = amc_pkg::ST_BURST; // see [RL15]
          end
        end
        default: nxt_state = state_ff;
      endcase
      if (burst_go) begin
        nxt_state = amc_pkg::ST_BURST; // see [RL12]
      end
    end else begin
      unique case (state_ff)
        amc_pkg::ST_WATCH: begin
          if (ACTIVITY_I) begin
            nxt_state = amc_pkg::ST_CONT; // see [RL7]
          end
        end
        amc_pkg::ST_BURST: begin
          if (burst_last) begin
            nxt_state = amc_pkg::ST_SLEEP; // see [RL10]
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_ff <= amc_pkg::ST_SLEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // burst length capture and sample count
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      burst_len_ff <= amc_pkg::BURST_MIN;
      burst_cnt_ff <= 8'h00;
    end else if (burst_go) begin
      // zero length runs one sample
      burst_len_ff <= (BURST_LENGTH_I == 8'h00) ? amc_pkg::BURST_MIN :
                      BURST_LENGTH_I; // see [RL14]
      burst_cnt_ff <= 8'h00;
    end else if ((state_ff == amc_pkg::ST_BURST) && SAMPLE_DONE_I &&
                 (burst_len_ff != amc_pkg::BURST_ENDLESS)) begin
      burst_cnt_ff <= burst_cnt_ff + amc_pkg::BURST_ONE; // see [RL10]
    end
  end

  // ==========================================================
  // reported state with settling lag
  always_comb begin
    unique case (state_ff)
      amc_pkg::ST_SLEEP: state_code = amc_pkg::SEL_SLEEP;
      amc_pkg::ST_STANDBY: state_code = amc_pkg::SEL_STANDBY;
      amc_pkg::ST_WATCH: state_code = amc_pkg::SEL_WATCH;
      amc_pkg::ST_CONT: state_code = amc_pkg::SEL_CONT;
      amc_pkg::ST_COMBINED: state_code = amc_pkg::SEL_COMBINED;
      amc_pkg::ST_BURST: state_code = amc_pkg::SEL_BURST;
      default: state_code = amc_pkg::SEL_SLEEP;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      last_code_ff <= amc_pkg::SEL_SLEEP;
      lag_cnt_ff <= '0;
      REPORTED_STATE_O <= amc_pkg::SEL_SLEEP;
    end else if (state_code != last_code_ff) begin
      last_code_ff <= state_code;
      lag_cnt_ff <= '0; // see [RL4]
    end else if (REPORTED_STATE_O != last_code_ff) begin
      if (lag_cnt_ff >= amc_pkg::LAG_W'(LAG_CYCLES - 1)) begin
        REPORTED_STATE_O <= last_code_ff; // see [RL4]
        lag_cnt_ff <= '0;
      end else begin
        lag_cnt_ff <= lag_cnt_ff + amc_pkg::LAG_W'(1);
      end
    end
  end

  // ==========================================================
  // registered controls to the sensing logic
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CLOCKS_EN_O <= 1'b0;
      POWER_DOWN_O <= 1'b1;
      WATCH_EN_O <= 1'b0;
      SAMPLING_EN_O <= 1'b0;
      FIFO_ALLOW_O <= 1'b0;
      BURST_ACTIVE_O <= 1'b0;
    end else begin
      CLOCKS_EN_O <= (state_ff != amc_pkg::ST_SLEEP); // see [RL5]
      POWER_DOWN_O <= (state_ff == amc_pkg::ST_SLEEP); // see [RL5]
      WATCH_EN_O <= (state_ff == amc_pkg::ST_WATCH) ||
                    (state_ff == amc_pkg::ST_COMBINED); // see [RL9]
      SAMPLING_EN_O <= (state_ff == amc_pkg::ST_CONT) ||
                       (state_ff == amc_pkg::ST_COMBINED) ||
                       (state_ff == amc_pkg::ST_BURST); // see [RL8]
      FIFO_ALLOW_O <= (state_ff == amc_pkg::ST_CONT) ||
                      (state_ff == amc_pkg::ST_COMBINED) ||
                      (state_ff == amc_pkg::ST_BURST); // see [RL9]
      BURST_ACTIVE_O <= (state_ff == amc_pkg::ST_BURST); // see [RL10]
    end
  end

  // ==========================================================
  // channel enables and state select field
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CHANNEL_EN_O <= 3'h7;
      STATE_SELECT_O <= amc_pkg::SEL_SLEEP;
    end else begin
      CHANNEL_EN_O[0] <= !ctrl_ff[amc_pkg::X_OFF_BIT]; // see [RL11]
      CHANNEL_EN_O[1] <= !ctrl_ff[amc_pkg::Y_OFF_BIT]; // see [RL11]
      CHANNEL_EN_O[2] <= !ctrl_ff[amc_pkg::Z_OFF_BIT]; // see [RL11]
      STATE_SELECT_O <= ctrl_ff[amc_pkg::SEL_MSB:amc_pkg::SEL_LSB];
    end
  end

endmodule

// ---- amc_mode_control_properties.sv ----
// concurrent checks on the operating state control ports
`timescale 1ns/1ps
module amc_mode_control_checker #(
  parameter int LAG_CYCLES = 8
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // stimulus side
  input wire logic WR_STB_I,
  input wire logic [7:0] WR_ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic ACTIVITY_I,
  // design side
  input wire logic [2:0] STATE_SELECT_O,
  input wire logic [2:0] REPORTED_STATE_O,
  input wire logic CLOCKS_EN_O,
  input wire logic POWER_DOWN_O,
  input wire logic WATCH_EN_O,
  input wire logic SAMPLING_EN_O,
  input wire logic FIFO_ALLOW_O,
  input wire logic BURST_ACTIVE_O,
  input wire logic [2:0] CHANNEL_EN_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  // ==========
  // cycles the clock, watch, sampling and burst enables have held still
  int steady_ff;
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      steady_ff <= 0;
    end else if (!$stable({CLOCKS_EN_O, WATCH_EN_O, SAMPLING_EN_O, BURST_ACTIVE_O})) begin
      steady_ff <= 0;
    end else if (steady_ff < 1000) begin
      steady_ff <= steady_ff + 1;
    end
  end
  sequence s_ctrl_write;
    WR_STB_I && WR_ADDR_I == 8'h10 ##1 !WR_STB_I;
  endsequence
  sequence s_watch_hit;
    WATCH_EN_O && !SAMPLING_EN_O && ACTIVITY_I && !WR_STB_I;
  endsequence
  // ==========
  // assertions
  a_field_write: assert property (
    s_ctrl_write |-> ##1 STATE_SELECT_O == $past(WR_DATA_I[2:0], 2))
    else $error("state field differs from write");
  a_channel_write: assert property (
    s_ctrl_write |-> ##1 CHANNEL_EN_O == ~$past(WR_DATA_I[6:4], 2))
    else $error("channel enables differ from write");
  a_watch_wakes: assert property (
    s_watch_hit |-> ##[1:3] (SAMPLING_EN_O && !WATCH_EN_O && STATE_SELECT_O == 3'h5))
    else $error("activity did not start sampling");
  a_sleep_quiet: assert property (
    POWER_DOWN_O |-> !(CLOCKS_EN_O || WATCH_EN_O || SAMPLING_EN_O || BURST_ACTIVE_O))
    else $error("activity while powered down");
  a_fifo_follow: assert property (
    FIFO_ALLOW_O == SAMPLING_EN_O)
    else $error("fifo permission differs from sampling");
  a_burst_entry: assert property (
    $rose(BURST_ACTIVE_O) |-> $past(CLOCKS_EN_O) && !$past(WATCH_EN_O) && !$past(SAMPLING_EN_O))
    else $error("burst entered from other than standby");
  a_burst_field: assert property (
    $rose(BURST_ACTIVE_O) |-> ##[0:2] STATE_SELECT_O == 3'h7)
    else $error("burst without field 111");
  a_report_lag: assert property (
    $changed(REPORTED_STATE_O) |->
      steady_ff >= ((LAG_CYCLES / 2 > 1000) ? 1000 : LAG_CYCLES / 2))
    else $error("reported state moved too early");
endmodule

bind amc_mode_control amc_mode_control_checker #(.LAG_CYCLES(LAG_CYCLES))
  i_amc_mode_control_checker (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .WR_STB_I(WR_STB_I), .WR_ADDR_I(WR_ADDR_I),
  .WR_DATA_I(WR_DATA_I), .ACTIVITY_I(ACTIVITY_I), .STATE_SELECT_O(STATE_SELECT_O),
  .REPORTED_STATE_O(REPORTED_STATE_O), .CLOCKS_EN_O(CLOCKS_EN_O),
  .POWER_DOWN_O(POWER_DOWN_O), .WATCH_EN_O(WATCH_EN_O), .SAMPLING_EN_O(SAMPLING_EN_O),
  .FIFO_ALLOW_O(FIFO_ALLOW_O), .BURST_ACTIVE_O(BURST_ACTIVE_O), .CHANNEL_EN_O(CHANNEL_EN_O));

// ---- amc_host_model.sv ----
// host side model driving the register write port
`timescale 1ns/1ps
module amc_host_model (
  // clock
  input wire logic clk_i,
  // write port
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  initial begin
    wr_stb_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
  end
  // one-cycle strobe; an idle bus shows the inverse of the last value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_stb_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d & 8'hf7;
    @(posedge clk_i);
    wr_stb_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
  endtask
endmodule

// ---- amc_mode_control_tb.sv ----
// self-checking bench for the operating state control block
`timescale 1ns/1ps
module amc_mode_control_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hb = 1'b0;
  logic act = 1'b0;
  logic done = 1'b0;
  logic ote = 1'b0;
  logic [7:0] blen = 8'h01;
  logic stb;
  logic [7:0] addr;
  logic [7:0] data;
  logic [2:0] sel;
  logic [2:0] rep;
  logic [2:0] chan;
  wire logic [5:0] obs;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // ==========
  // clock, design and host
  always #25 clock = ~clock;
  amc_host_model i_amc_host_model (.clk_i(clock), .wr_stb_o(stb), .wr_addr_o(addr),
    .wr_data_o(data));
  amc_mode_control #(.LAG_CYCLES(8)) i_amc_mode_control (
    .CLOCK_I(clock), .NRST_I(nrst), .WR_STB_I(stb), .WR_ADDR_I(addr), .WR_DATA_I(data),
    .HEARTBEAT_I(hb), .ACTIVITY_I(act), .SAMPLE_DONE_I(done), .BURST_LENGTH_I(blen),
    .OUTSIDE_TRIGGER_ENABLE_I(ote), .STATE_SELECT_O(sel), .REPORTED_STATE_O(rep),
    .CLOCKS_EN_O(obs[5]), .POWER_DOWN_O(obs[4]), .WATCH_EN_O(obs[3]),
    .SAMPLING_EN_O(obs[2]), .FIFO_ALLOW_O(obs[1]), .BURST_ACTIVE_O(obs[0]),
    .CHANNEL_EN_O(chan));
  // ==========
  // helpers
  function automatic logic [5:0] ctl(input logic [2:0] c);
    case (c)
      3'h0: ctl = 6'h10;
      3'h1: ctl = 6'h20;
      3'h2: ctl = 6'h28;
      3'h5: ctl = 6'h26;
      3'h6: ctl = 6'h2e;
      default: ctl = 6'h27;
    endcase
  endfunction
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apply(input logic [7:0] a, input logic [7:0] d);
    i_amc_host_model.write(a, d);
    tick(2);
    hb <= ~hb;
    tick(10);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      done <= 1'b1;
      tick(1);
      done <= 1'b0;
      tick(1);
    end
    tick(3);
  endtask
  task automatic expect_state(input logic [2:0] c);
    check("field", {3'h0, sel}, {3'h0, c});
    check("controls", obs, ctl(c));
  endtask
  // ==========
  // scenarios
  task automatic t_states();
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
    logic [2:0] prev = 3'h0;
    for (int i = 0; i < 5; i++) begin
      apply(8'h10, {1'b0, i[2:0], 1'b0, codes[i]});
      expect_state(codes[i]);
      check("channels", {3'h0, chan}, {3'h0, ~i[2:0]});
      check("early report", {3'h0, rep}, {3'h0, prev});
      tick(14);
      check("report", {3'h0, rep}, {3'h0, codes[i]});
      prev = codes[i];
    end
  endtask
  task automatic t_burst();
    blen <= 8'h03;
    apply(8'h10, 8'h01);
    apply(8'h10, 8'h81);
    expect_state(3'h7);
    pulses(2);
    expect_state(3'h7);
    pulses(1);
    expect_state(3'h0);
  endtask
  task automatic t_refuse();
    apply(8'h10, 8'h02);
    apply(8'h10, 8'h07);
    check("controls", obs, ctl(3'h2));
    apply(8'h10, 8'h01);
    ote <= 1'b1;
    apply(8'h10, 8'h07);
    check("controls", obs, ctl(3'h1));
    ote <= 1'b0;
  endtask
  task automatic t_endless();
    blen <= 8'hff;
    apply(8'h10, 8'h07);
    pulses(4);
    expect_state(3'h7);
    apply(8'h10, 8'h01);
    expect_state(3'h1);
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    tick(6);
    nrst <= 1'b1;
    tick(1);
    check("channels", {3'h0, chan}, 6'h07);
    expect_state(3'h0);
    t_states();
    apply(8'h11, 8'h05);
    expect_state(3'h0);
    apply(8'h10, 8'h02);
    act <= 1'b1;
    tick(1);
    act <= 1'b0;
    tick(4);
    expect_state(3'h5);
    t_burst();
    t_refuse();
    t_endless();
    conclude();
  end
endmodule
